// >>> rtl/hwmove_pkg.sv
// Package of encodings, register offsets and carriers for the move decoder
package hwmove_pkg;
  // ---------------------------------------------------------------
  // Instruction encodings
  // ---------------------------------------------------------------
  localparam logic [5:0] OP_SPECIAL   = 6'h00;
  localparam logic [5:0] OP_COP0      = 6'h10;
  localparam logic [5:0] OP_COP1      = 6'h11;
  localparam logic [5:0] OP_COP2      = 6'h12;
  localparam logic [4:0] SUB_HIGH0    = 5'h02;
  localparam logic [4:0] SUB_HIGH     = 5'h03;
  localparam logic [5:0] FN_MUL_HIGH  = 6'h10;
  localparam logic [5:0] FN_MUL_LOW   = 6'h12;
  localparam logic [5:0] FN_FP_COPY   = 6'h06;
  localparam logic [5:0] FN_MOVE_CF   = 6'h01;
  localparam logic [4:0] FMT_SINGLE   = 5'h10;
  localparam logic [4:0] FMT_DOUBLE   = 5'h11;
  localparam logic [4:0] FMT_PAIRED   = 5'h16;
  localparam logic [3:0] REV_NEWEST   = 4'h6;
  localparam logic [3:0] REV_FP_HIGH  = 4'h2;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_MASK    = 8'h08;
  localparam logic [7:0] ADDR_COUNT   = 8'h0c;
  // Control fields
  localparam int CTRL_MVH_BIT         = 0;
  localparam int CTRL_FRM_BIT         = 1;
  localparam int CTRL_REV_LSB         = 4;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0061;
  // Status bit positions
  localparam int EV_RESINST           = 0;
  localparam int EV_COPUNUSE          = 1;
  localparam int EV_UNIMPOP           = 2;
  localparam int EV_DONE              = 3;
  localparam int NUM_EV               = 4;
  localparam logic [1:0] RESP_OKAY    = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;

  typedef enum logic [2:0] {
    EXC_NONE    = 3'b001,
    EXC_RESINST = 3'b010,
    EXC_COPUSE  = 3'b100
  } exc_type;

  // Decoded instruction issue
  typedef struct packed {
    logic        valid;
    logic [31:0] word;
  } issue_type;

  // Operand values offered by the pipeline
  typedef struct packed {
    logic [63:0] sys_value;
    logic        sys_present;
    logic        sys_extended;
    logic [63:0] fp_value;
    logic [63:0] cop2_value;
    logic [31:0] mul_high_result;
    logic [31:0] mul_low_result;
    logic [31:0] gpr_source;
    logic [7:0]  fp_cond;
    logic        cop1_usable;
    logic        fp_fmt_impl;
  } operand_type;

  // Result towards the register files
  typedef struct packed {
    logic        gpr_we;
    logic [4:0]  gpr_addr;
    logic [31:0] gpr_data;
    logic        fpr_we;
    logic [4:0]  fpr_addr;
    logic [63:0] fpr_data;
    exc_type     exc;
    logic        unimpl_op;
    logic        done;
  } result_type;
endpackage

// >>> rtl/high_word_register_move.sv
// Decode and execute of high-word and register-move instructions
// Summary of operation
// (RULE1) COP0 sub 00010 moves system reg high word
// (RULE2) Reserved instruction when high-half enable clear
// (RULE3) Newest revision: missing or narrow register gives 0
// (RULE4) Software zeroes select for unselectable registers
// (RULE5) Translation entry lows returned unmodified
// (RULE6) COP1 sub 00011 moves FP high word
// (RULE7) Before revision 2 FP high move reserved
// (RULE8) COP2 sub 00011 moves coprocessor-2 high word
// (RULE9) Software names only existing 64-bit COP2 registers
// (RULE10) Function 010000 copies multiply high result
// (RULE11) Function 010010 copies multiply low result
// (RULE12) COP1 function 000110 copies FP register
// (RULE13) Paired single copies both halves, not newest
// (RULE14) FP copy raises no IEEE flags
// (RULE15) FP copy signals unusable or reserved exceptions
// (RULE16) Software names valid FP registers for format
// (RULE17) Condition false moves general register
// (RULE18) Condition true leaves destination unwritten
`timescale 1ns/1ns
module high_word_register_move (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire hwmove_pkg::issue_type    issue,
  input  wire hwmove_pkg::operand_type  opnd,
  output hwmove_pkg::result_type        result,
  output logic [4:0]                    sys_reg_sel,
  output logic [2:0]                    sys_sel_field,
  output logic [4:0]                    fp_reg_sel,
  output logic [15:0]                   cop2_impl_field,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  output logic [1:0]                    s_axi_bresp,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  input  wire logic [7:0]               s_axi_araddr,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          irq
);
  // ---------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------
  logic [31:0] w;
  logic [5:0]  op;
  logic [4:0]  rs;
  logic [4:0]  rt;
  logic [4:0]  rd;
  logic [4:0]  sa;
  logic [5:0]  fn;
  logic [31:0] ctrl_r;
  logic [3:0]  rev;
  logic        high_half_sys_move_enable;
  logic        fp_register_width_mode;
  logic [2:0]  fp_condition_select;
  logic        true_false_select;

  assign w   = issue.word;
  assign op  = w[31:26];
  assign rs  = w[25:21];
  assign rt  = w[20:16];
  assign rd  = w[15:11];
  assign sa  = w[10:6];
  assign fn  = w[5:0];
  assign fp_condition_select = w[20:18];
  assign true_false_select   = w[16];
  assign high_half_sys_move_enable =
    ctrl_r[hwmove_pkg::CTRL_MVH_BIT];
  assign fp_register_width_mode = ctrl_r[hwmove_pkg::CTRL_FRM_BIT];
  assign rev = ctrl_r[hwmove_pkg::CTRL_REV_LSB +: 4];

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic dec_sys_high;
  logic dec_fp_high;
  logic dec_cop2_high;
  logic dec_mul_high;
  logic dec_mul_low;
  logic dec_fp_copy;
  logic dec_move_false;
  logic newest;
  logic fmt_paired;
  logic fmt_known;

  assign newest = rev >= hwmove_pkg::REV_NEWEST;
  assign dec_sys_high = issue.valid && op == hwmove_pkg::OP_COP0 &&
    rs == hwmove_pkg::SUB_HIGH0 && w[10:3] == 8'h00; // RULE1
  assign dec_fp_high = issue.valid && op == hwmove_pkg::OP_COP1 &&
    rs == hwmove_pkg::SUB_HIGH && w[10:0] == 11'h000; // RULE6
  assign dec_cop2_high = issue.valid && op == hwmove_pkg::OP_COP2 &&
    rs == hwmove_pkg::SUB_HIGH; // RULE8
  assign dec_mul_high = issue.valid && op == hwmove_pkg::OP_SPECIAL &&
    fn == hwmove_pkg::FN_MUL_HIGH && w[25:16] == 10'h000 &&
    sa == 5'h00; // RULE10
  assign dec_mul_low = issue.valid && op == hwmove_pkg::OP_SPECIAL &&
    fn == hwmove_pkg::FN_MUL_LOW && w[25:16] == 10'h000 &&
    sa == 5'h00; // RULE11
  assign dec_fp_copy = issue.valid && op == hwmove_pkg::OP_COP1 &&
    fn == hwmove_pkg::FN_FP_COPY && rt == 5'h00 &&
    rs >= hwmove_pkg::FMT_SINGLE; // RULE12
  assign dec_move_false = issue.valid && op == hwmove_pkg::OP_SPECIAL &&
    fn == hwmove_pkg::FN_MOVE_CF && w[17] == 1'b0 &&
    !true_false_select && sa == 5'h00; // RULE17
  assign fmt_paired = rs == hwmove_pkg::FMT_PAIRED;
  assign fmt_known  = rs == hwmove_pkg::FMT_SINGLE ||
    rs == hwmove_pkg::FMT_DOUBLE || fmt_paired;

  // Operand selects towards the register sources
  assign sys_reg_sel     = rd;
  assign sys_sel_field   = w[2:0];
  assign fp_reg_sel      = rd;
  assign cop2_impl_field = w[15:0];

  // ---------------------------------------------------------------
  // Execute
  // ---------------------------------------------------------------
  hwmove_pkg::result_type res_nxt;
  logic cond_false;

  assign cond_false = opnd.fp_cond[fp_condition_select] == 1'b0;

  always_comb begin
    res_nxt = '0;
    res_nxt.exc = hwmove_pkg::EXC_NONE;
    if (dec_sys_high) begin
      if (!high_half_sys_move_enable) begin
        res_nxt.exc = hwmove_pkg::EXC_RESINST; // RULE2
      end else begin
        res_nxt.gpr_we   = 1'b1;
        res_nxt.gpr_addr = rt;
        // Entry-low high halves pass straight through
        if (opnd.sys_present && opnd.sys_extended) begin
          res_nxt.gpr_data = opnd.sys_value[63:32]; // RULE1 RULE5
        end else begin
          res_nxt.gpr_data = 32'h0000_0000; // RULE3
        end
      end
    end else if (dec_fp_high) begin
      if (rev < hwmove_pkg::REV_FP_HIGH) begin
        res_nxt.exc = hwmove_pkg::EXC_RESINST; // RULE7
      end else if (!opnd.cop1_usable) begin
        res_nxt.exc = hwmove_pkg::EXC_COPUSE;
      end else begin
        res_nxt.gpr_we   = 1'b1;
        res_nxt.gpr_addr = rt;
        res_nxt.gpr_data = opnd.fp_value[63:32]; // RULE6
      end
    end else if (dec_cop2_high) begin
      if (rev < hwmove_pkg::REV_FP_HIGH) begin
        res_nxt.exc = hwmove_pkg::EXC_RESINST;
      end else begin
        res_nxt.gpr_we   = 1'b1;
        res_nxt.gpr_addr = rt;
        res_nxt.gpr_data = opnd.cop2_value[63:32]; // RULE8
      end
    end else if (dec_mul_high || dec_mul_low) begin
      if (newest) begin
        res_nxt.exc = hwmove_pkg::EXC_RESINST; // RULE10 RULE11
      end else begin
        res_nxt.gpr_we   = 1'b1;
        res_nxt.gpr_addr = rd;
        res_nxt.gpr_data = dec_mul_high ? opnd.mul_high_result
                                        : opnd.mul_low_result;
      end
    end else if (dec_fp_copy) begin
      if (!opnd.cop1_usable) begin
        res_nxt.exc = hwmove_pkg::EXC_COPUSE; // RULE15
      end else if (!fmt_known || (fmt_paired && newest)) begin
        res_nxt.exc = hwmove_pkg::EXC_RESINST; // RULE13 RULE15
      end else if (!opnd.fp_fmt_impl ||
                   (fmt_paired && !fp_register_width_mode)) begin
        res_nxt.unimpl_op = 1'b1; // RULE15
      end else begin
        // Plain copy, no arithmetic flags touched
        res_nxt.fpr_we   = 1'b1; // RULE12 RULE14
        res_nxt.fpr_addr = sa;
        res_nxt.fpr_data = opnd.fp_value; // RULE13
      end
    end else if (dec_move_false) begin
      if (newest) begin
        res_nxt.exc = hwmove_pkg::EXC_RESINST;
      end else if (!opnd.cop1_usable) begin
        res_nxt.exc = hwmove_pkg::EXC_COPUSE;
      end else begin
        res_nxt.gpr_we   = cond_false; // RULE17 RULE18
        res_nxt.gpr_addr = rd;
        res_nxt.gpr_data = opnd.gpr_source;
      end
    end
    res_nxt.done = dec_sys_high | dec_fp_high | dec_cop2_high |
      dec_mul_high | dec_mul_low | dec_fp_copy | dec_move_false;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result <= '0;
      result.exc <= hwmove_pkg::EXC_NONE;
    end else begin
      result <= res_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [hwmove_pkg::NUM_EV-1:0] status_r;
  logic [hwmove_pkg::NUM_EV-1:0] mask_r;
  logic [hwmove_pkg::NUM_EV-1:0] ev;
  logic [31:0] count_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_go;
  logic        rd_go;
  logic        status_read;
  logic [31:0] rdata_nxt;

  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign status_read = rd_go && s_axi_araddr == hwmove_pkg::ADDR_STATUS;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= hwmove_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r == hwmove_pkg::ADDR_CTRL ||
                         awaddr_r == hwmove_pkg::ADDR_MASK)
                        ? hwmove_pkg::RESP_OKAY : hwmove_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control and mask registers with byte enables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= hwmove_pkg::CTRL_RESET;
      mask_r <= '0;
    end else if (wr_go) begin
      if (awaddr_r == hwmove_pkg::ADDR_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_r[b]) begin
            ctrl_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
          end
        end
      end
      if (awaddr_r == hwmove_pkg::ADDR_MASK && wstrb_r[0]) begin
        mask_r <= wdata_r[hwmove_pkg::NUM_EV-1:0];
      end
    end
  end

  // Sticky events; a new event wins over the read clear
  assign ev[hwmove_pkg::EV_RESINST]  =
    res_nxt.exc == hwmove_pkg::EXC_RESINST;
  assign ev[hwmove_pkg::EV_COPUNUSE] =
    res_nxt.exc == hwmove_pkg::EXC_COPUSE;
  assign ev[hwmove_pkg::EV_UNIMPOP]  = res_nxt.unimpl_op;
  assign ev[hwmove_pkg::EV_DONE]     = res_nxt.done;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= '0;
      irq      <= 1'b0;
      count_r  <= 32'h0000_0000;
    end else begin
      status_r <= (status_read ? '0 : status_r) | ev;
      irq      <= |(((status_read ? '0 : status_r) | ev) & mask_r);
      if (res_nxt.done) begin
        count_r <= count_r + 32'h0000_0001;
      end
    end
  end

  always_comb begin
    case (s_axi_araddr)
      hwmove_pkg::ADDR_CTRL:   rdata_nxt = ctrl_r;
      hwmove_pkg::ADDR_STATUS: rdata_nxt = 32'(status_r);
      hwmove_pkg::ADDR_MASK:   rdata_nxt = 32'(mask_r);
      hwmove_pkg::ADDR_COUNT:  rdata_nxt = count_r;
      default:                 rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= hwmove_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_nxt;
        s_axi_rresp  <= s_axi_araddr[7:4] == 4'h0
                        ? hwmove_pkg::RESP_OKAY : hwmove_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence sys_high_ok;
    dec_sys_high && high_half_sys_move_enable;
  endsequence

  AST_SYS_HIGH: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
    (sys_high_ok and (opnd.sys_present && opnd.sys_extended)) |=>
    result.gpr_we && result.gpr_data == $past(opnd.sys_value[63:32]))
    else $error("system high word not moved");
  AST_MVH_OFF: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
    dec_sys_high && !high_half_sys_move_enable |=>
    result.exc == hwmove_pkg::EXC_RESINST && !result.gpr_we)
    else $error("high move not reserved when disabled");
  AST_SYS_ZERO: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
    (sys_high_ok and !(opnd.sys_present && opnd.sys_extended)) |=>
    result.gpr_we && result.gpr_data == 32'h0000_0000)
    else $error("absent system register not zero");
  AST_FP_HIGH: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
    dec_fp_high && rev >= hwmove_pkg::REV_FP_HIGH && opnd.cop1_usable |=>
    result.gpr_data == $past(opnd.fp_value[63:32]) &&
    result.gpr_addr == $past(rt))
    else $error("fp high word wrong");
  AST_FP_OLD: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
    dec_fp_high && rev < hwmove_pkg::REV_FP_HIGH |=>
    result.exc == hwmove_pkg::EXC_RESINST)
    else $error("old revision fp high not reserved");
  AST_MUL: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
    dec_mul_high && !newest |=>
    result.gpr_data == $past(opnd.mul_high_result) && result.gpr_we)
    else $error("multiply high copy wrong");
  AST_FP_COPY: assert property (@(posedge aclk) disable iff (!aresetn) // RULE14
    res_nxt.fpr_we |=> result.fpr_addr == $past(sa) &&
    !result.unimpl_op && result.exc == hwmove_pkg::EXC_NONE)
    else $error("fp copy raised a flag");
  AST_COND: assert property (@(posedge aclk) disable iff (!aresetn) // RULE18
    dec_move_false && !newest && opnd.cop1_usable && !cond_false |=>
    !result.gpr_we)
    else $error("conditional move wrote on true");
endmodule // high_word_register_move

// >>> dv/pipe_model.sv
// Pipeline model offering operands for the selected registers
`timescale 1ns/1ns
module pipe_model (
  input  wire logic [4:0]          sys_reg_sel,
  input  wire logic [2:0]          sys_sel_field,
  input  wire logic [4:0]          fp_reg_sel,
  input  wire logic [15:0]         cop2_impl_field,
  input  wire logic [7:0]          fp_cond,
  input  wire logic                cop1_usable,
  input  wire logic                fp_fmt_impl,
  output hwmove_pkg::operand_type  opnd
);
  // ---------------------------------------------------------------
  // Operand lookup, same cycle as the selectors
  // ---------------------------------------------------------------
  always_comb begin
    opnd.sys_value       = {8'h5a, sys_sel_field, sys_reg_sel, 16'hc3c3,
                            32'h1234_5678};
    // Register 15 absent, 16 and up only 32 bits wide
    opnd.sys_present     = (sys_reg_sel != 5'h0f);
    opnd.sys_extended    = ~sys_reg_sel[4];
    // Every named register holds a value of the requested format
    opnd.fp_value        = {8'h3c, 3'h0, fp_reg_sel, 16'h0f0f,
                            32'h9abc_def0};
    // Every named register exists and is 64 bits wide
    opnd.cop2_value      = {cop2_impl_field, 16'h7e7e, 32'h0};
    opnd.mul_high_result = 32'h1111_2222;
    opnd.mul_low_result  = 32'h3333_4444;
    opnd.gpr_source      = 32'h5555_6666;
    opnd.fp_cond         = fp_cond;
    opnd.cop1_usable     = cop1_usable;
    opnd.fp_fmt_impl     = fp_fmt_impl;
  end
endmodule // pipe_model

// >>> dv/high_word_register_move_bench.sv
// Self-checking bench for the high-word and register-move decoder
`timescale 1ns/1ns
module high_word_register_move_bench;
  logic                    aclk;
  logic                    aresetn;
  hwmove_pkg::issue_type   issue;
  hwmove_pkg::operand_type opnd;
  hwmove_pkg::result_type  result;
  logic [4:0]              sys_reg_sel;
  logic [2:0]              sys_sel_field;
  logic [4:0]              fp_reg_sel;
  logic [15:0]             cop2_impl_field;
  logic [7:0]              fp_cond;
  logic                    cop1_usable;
  logic                    fp_fmt_impl;
  logic                    s_axi_awvalid;
  logic                    s_axi_awready;
  logic [7:0]              s_axi_awaddr;
  logic                    s_axi_wvalid;
  logic                    s_axi_wready;
  logic [31:0]             s_axi_wdata;
  logic [3:0]              s_axi_wstrb;
  logic                    s_axi_bvalid;
  logic                    s_axi_bready;
  logic [1:0]              s_axi_bresp;
  logic                    s_axi_arvalid;
  logic                    s_axi_arready;
  logic [7:0]              s_axi_araddr;
  logic                    s_axi_rvalid;
  logic                    s_axi_rready;
  logic [31:0]             s_axi_rdata;
  logic [1:0]              s_axi_rresp;
  logic                    irq;
  logic [31:0]             d;
  logic [1:0]              r;
  logic [31:0]             c0;
  int                      miscompares = 0;
  int                      n_tests = 0;

  high_word_register_move i_high_word_register_move (.aclk(aclk),
    .aresetn(aresetn), .issue(issue), .opnd(opnd), .result(result),
    .sys_reg_sel(sys_reg_sel), .sys_sel_field(sys_sel_field),
    .fp_reg_sel(fp_reg_sel), .cop2_impl_field(cop2_impl_field),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .irq(irq));
  pipe_model i_pipe_model (.sys_reg_sel(sys_reg_sel),
    .sys_sel_field(sys_sel_field), .fp_reg_sel(fp_reg_sel),
    .cop2_impl_field(cop2_impl_field), .fp_cond(fp_cond),
    .cop1_usable(cop1_usable), .fp_fmt_impl(fp_fmt_impl), .opnd(opnd));

  always #50 aclk = ~aclk;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] e,
                     input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One issue, result checked one cycle later
  task automatic exec(input logic [31:0] w);
    @(posedge aclk);
    issue <= '{valid: 1'b1, word: w};
    @(posedge aclk);
    issue <= '0;
    #1;
  endtask

  task automatic chk_gpr(input logic we, input logic [4:0] a,
                         input logic [31:0] v, input logic [2:0] ex);
    chk("gpr_we", 64'(we), 64'(result.gpr_we));
    if (we) chk("gpr_addr", 64'(a), 64'(result.gpr_addr));
    if (we) chk("gpr_data", 64'(v), 64'(result.gpr_data));
    chk("exc", 64'(ex), 64'(result.exc));
    chk("done", 64'h1, 64'(result.done));
  endtask

  task automatic chk_fpr(input logic we, input logic [63:0] v,
                         input logic un, input logic [2:0] ex);
    chk("fpr_we", 64'(we), 64'(result.fpr_we));
    if (we) chk("fpr_addr", 64'h14, 64'(result.fpr_addr));
    if (we) chk("fpr_data", v, result.fpr_data);
    chk("unimpl_op", 64'(un), 64'(result.unimpl_op));
    chk("exc", 64'(ex), 64'(result.exc));
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    aclk = 0;
    aresetn = 0;
    issue = '0;
    fp_cond = 8'h00;
    cop1_usable = 1;
    fp_fmt_impl = 1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(8'h00); chk("ctrl", 64'h61, 64'(d));
    axi_rd(8'h08); chk("mask", 64'h0, 64'(d));
    axi_rd(8'h04); chk("status", 64'h0, 64'(d));
    // High words of present, extended registers; select field zero
    for (int k = 2; k <= 4; k++) begin
      exec({6'h10, 5'h02, 5'd3, 5'(k), 8'h00, 3'h0});
      chk_gpr(1, 5'd3, {8'h5a, 3'h0, 5'(k), 16'hc3c3}, 3'b001);
    end
    exec({6'h10, 5'h02, 5'd3, 5'd15, 8'h00, 3'h0});
    chk_gpr(1, 5'd3, 32'h0, 3'b001);
    exec({6'h10, 5'h02, 5'd3, 5'd16, 8'h00, 3'h0});
    chk_gpr(1, 5'd3, 32'h0, 3'b001);
    exec({6'h11, 5'h03, 5'd7, 5'd6, 11'h0});
    chk_gpr(1, 5'd7, 32'h3c06_0f0f, 3'b001);
    exec({6'h12, 5'h03, 5'd9, 16'habcd});
    chk_gpr(1, 5'd9, 32'habcd_7e7e, 3'b001);
    exec({6'h11, 5'h10, 5'h0, 5'd6, 5'd20, 6'h06});
    chk_fpr(1, 64'h3c06_0f0f_9abc_def0, 0, 3'b001);
    cop1_usable <= 1'b0;
    exec({6'h11, 5'h11, 5'h0, 5'd6, 5'd20, 6'h06});
    chk_fpr(0, 64'h0, 0, 3'b100);
    cop1_usable <= 1'b1;
    fp_fmt_impl <= 1'b0;
    exec({6'h11, 5'h10, 5'h0, 5'd6, 5'd20, 6'h06});
    chk_fpr(0, 64'h0, 1, 3'b001);
    fp_fmt_impl <= 1'b1;
    exec({6'h00, 10'h0, 5'd12, 5'h0, 6'h10});
    chk_gpr(0, 5'd12, 32'h0, 3'b010);
    chk("irq", 64'h0, 64'(irq));
    // Older revisions, wide register mode first, then narrow register mode
    axi_wr(8'h00, 32'h53); axi_rd(8'h00); chk("ctrl", 64'h53, 64'(d));
    exec({6'h00, 10'h0, 5'd12, 5'h0, 6'h10});
    chk_gpr(1, 5'd12, 32'h1111_2222, 3'b001);
    exec({6'h00, 10'h0, 5'd12, 5'h0, 6'h12});
    chk_gpr(1, 5'd12, 32'h3333_4444, 3'b001);
    exec({6'h11, 5'h16, 5'h0, 5'd6, 5'd20, 6'h06});
    chk_fpr(1, 64'h3c06_0f0f_9abc_def0, 0, 3'b001);
    for (int b = 0; b < 8; b++) begin
      fp_cond <= 8'hff ^ (8'h1 << b);
      exec({6'h00, 5'd1, 3'd2, 1'b0, 1'b0, 5'd13, 5'h0, 6'h01});
      chk_gpr(b == 2, 5'd13, 32'h5555_6666, 3'b001);
    end
    fp_cond <= 8'h00;
    axi_wr(8'h00, 32'h51);
    exec({6'h11, 5'h16, 5'h0, 5'd6, 5'd20, 6'h06});
    chk_fpr(0, 64'h0, 1, 3'b001);
    axi_wr(8'h00, 32'h11);
    exec({6'h11, 5'h03, 5'd7, 5'd6, 11'h0});
    chk_gpr(0, 5'd7, 32'h0, 3'b010);
    exec({6'h12, 5'h03, 5'd9, 16'habcd});
    chk_gpr(0, 5'd9, 32'h0, 3'b010);
    // Reserved event raises the interrupt, a status read clears it
    axi_wr(8'h08, 32'h1);
    axi_rd(8'h04);
    axi_wr(8'h00, 32'h60);
    exec({6'h10, 5'h02, 5'd3, 5'd4, 8'h00, 3'h0});
    chk_gpr(0, 5'd3, 32'h0, 3'b010);
    @(posedge aclk); #1;
    chk("irq", 64'h1, 64'(irq));
    axi_rd(8'h04); chk("status_bit0", 64'h1, 64'(d[0]));
    @(posedge aclk); @(posedge aclk); #1;
    chk("irq", 64'h0, 64'(irq));
    axi_rd(8'h04); chk("status_bit0", 64'h0, 64'(d[0]));
    axi_wr(8'h10, 32'h5); chk("bresp", 64'h2, 64'(r));
    axi_rd(8'h1c); chk("rresp", 64'h2, 64'(r));
    chk("rdata", 64'h0, 64'(d));
    // One decoded instruction advances the count by one
    axi_rd(8'h0c); c0 = d;
    exec({6'h12, 5'h03, 5'd9, 16'habcd});
    axi_rd(8'h0c); chk("count", 64'(c0 + 32'h1), 64'(d));
    give_verdict();
  end

  initial begin
    #(20000 * 100);
    miscompares++;
    give_verdict();
  end
endmodule // high_word_register_move_bench
